//--- hdl/rsu_sequencer.sv
// Purpose: Records reconfiguration causes and selects the next image.
// Assumes: Trigger inputs are synchronous levels; image_loaded is a pulse.
// Notes: Watchdog counting and image loading are done outside this block.
module rsu_sequencer
  import rsu_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic external_config_reset,
  input wire logic config_error_pin,
  input wire logic crc_error,
  input wire logic watchdog_timeout,
  input wire logic fabric_reconfig_request,
  input wire logic image_loaded,
  input wire logic ru_shift_en,
  input wire logic ru_shift_in,
  input wire logic ru_capture,
  input wire logic [2:0] ru_capture_sel,
  input wire logic ru_update,
  output logic ru_shift_out,
  output logic load_request,
  output logic load_application,
  output logic [23:0] load_address,
  output logic early_done_check,
  output logic internal_osc_select,
  output logic watchdog_enable_bit,
  output logic [28:0] watchdog_timeout_value,
  output logic [1:0] master_state
);

  rsu_shift_if sif ();

  rsu_state_t state;
  logic [CTL_W-1:0] control;
  logic [HIST_W-1:0] reconfig_history_recent;
  logic [HIST_W-1:0] reconfig_history_older;
  logic history_valid;
  logic target_app;
  logic req_prev;
  logic [SRC_W-1:0] raw_src;
  logic [SRC_W-1:0] next_source;
  logic req_rise;
  logic any_event;
  logic [23:0] boot_addr;
  logic [28:0] wd_value;
  logic [1:0] ms_code;
  logic [STAT_W-1:0] reconfig_current_state;
  logic [STAT_W-1:0] info2_word;
  logic [CTL_W-1:0] next_capture;

  // ----------------------------------------------------------------------
  // Event detection.
  // ----------------------------------------------------------------------
  // The fabric request acts on its rising edge only.
  always_ff @(posedge mclk) begin
    if (srst) begin
      req_prev <= 1'b0;
    end else begin
      req_prev <= fabric_reconfig_request;
    end
  end

  // The partner keeps the request high long enough to be seen here.
  assign req_rise = fabric_reconfig_request && !req_prev;
  assign raw_src[SRC_EXT_RESET] = external_config_reset;
  assign raw_src[SRC_CRC] = crc_error;
  assign raw_src[SRC_ERR_PIN] = config_error_pin;
  assign raw_src[SRC_WATCHDOG] = watchdog_timeout;
  assign raw_src[SRC_FABRIC] = req_rise;
  assign any_event = |raw_src;

  // Keep only the highest-numbered source when several coincide.
  always_comb begin
    next_source = '0;
    for (int i = 0; i < SRC_W; i++) begin
      if (raw_src[i]) begin
        next_source = SRC_W'(1) << i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Derived fields.
  // ----------------------------------------------------------------------
  assign boot_addr = {control[CTL_ADDR_HI:CTL_ADDR_LO], 2'b00};
  assign wd_value = {control[CTL_WD_HI:0], WD_LOW_BITS};
  assign ms_code = (state == RSU_ST_APP) ? MS_APPLICATION : MS_FACTORY;

  // ----------------------------------------------------------------------
  // Master state machine.
  // ----------------------------------------------------------------------
  // Events are taken only in a running image; the status and history are
  // written on entry to the record state, one cycle before the load is requested.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= RSU_ST_LOAD;
    end else begin
      case (state)
        RSU_ST_FACTORY, RSU_ST_APP: begin
          if (any_event) begin
            state <= RSU_ST_RECORD;
          end
        end
        RSU_ST_RECORD: begin
          state <= RSU_ST_LOAD;
        end
        RSU_ST_LOAD: begin
          if (image_loaded) begin
            state <= target_app ? RSU_ST_APP : RSU_ST_FACTORY;
          end
        end
        default: begin
          state <= RSU_ST_LOAD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control register and image target.
  // ----------------------------------------------------------------------
  // Errors force all bits low, selecting factory; a fabric request takes
  // the update word and selects the application image.
  always_ff @(posedge mclk) begin
    if (srst) begin
      control <= CTL_RESET;
      target_app <= 1'b0;
    end else if ((state == RSU_ST_FACTORY || state == RSU_ST_APP) &&
                 any_event) begin
      if (next_source[SRC_FABRIC]) begin
        control <= sif.update_word;
        target_app <= 1'b1;
      end else begin
        control <= CTL_RESET;
        target_app <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Cause and history.
  // ----------------------------------------------------------------------
  // Leaving an application pushes a new entry and ages the old one.
  always_ff @(posedge mclk) begin
    if (srst) begin
      reconfig_history_recent <= '0;
      reconfig_history_older <= '0;
      history_valid <= 1'b0;
    end else begin
      if ((state == RSU_ST_FACTORY || state == RSU_ST_APP) && any_event) begin
        if (state == RSU_ST_APP) begin
          reconfig_history_older <= reconfig_history_recent;
          reconfig_history_recent <= {next_source, ms_code, boot_addr};
        end
      end
      if (state == RSU_ST_APP) begin
        history_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status words and capture.
  // ----------------------------------------------------------------------
  // Factory shows the boot address; application shows watchdog settings.
  always_comb begin
    if (state == RSU_ST_APP) begin
      reconfig_current_state = {ms_code, control[CTL_WATCHDOG_ENABLE_BIT], wd_value};
    end else begin
      reconfig_current_state = {ms_code, 6'h00, boot_addr};
    end
  end

  assign info2_word = {ms_code, 6'h00, boot_addr};

  // Select the word copied into the shift register on a capture.
  always_comb begin
    next_capture = '0;
    case (ru_capture_sel)
      SEL_INFO1: next_capture = {7'h00, reconfig_current_state};
      SEL_INFO2: next_capture = {7'h00, info2_word};
      SEL_HIST_RECENT: begin
        next_capture = history_valid ?
          {8'h00, reconfig_history_recent} :
          {7'h00, HIST_INVALID_WORD};
      end
      SEL_HIST_OLDER: begin
        next_capture = history_valid ?
          {8'h00, reconfig_history_older} :
          {7'h00, HIST_INVALID_WORD};
      end
      SEL_CONTROL: begin
        next_capture = (state == RSU_ST_APP) ? control : sif.update_word;
      end
      default: next_capture = '0;
    endcase
  end

  assign sif.capture_strobe = ru_capture;
  assign sif.capture_word = next_capture;
  assign sif.update_write_en = (state == RSU_ST_FACTORY);

  rsu_shift_unit u_shift (
    .mclk(mclk),
    .srst(srst),
    .shift_en(ru_shift_en),
    .shift_in(ru_shift_in),
    .update(ru_update),
    .shift_out(ru_shift_out),
    .sif(sif)
  );

  // ----------------------------------------------------------------------
  // Outputs towards the configuration engine.
  // ----------------------------------------------------------------------
  // The load request stands for the whole load wait.
  assign load_request = (state == RSU_ST_LOAD);
  assign load_application = target_app;
  assign load_address = boot_addr;
  assign early_done_check = control[CTL_EARLY_DONE];
  assign internal_osc_select = control[CTL_OSC_INT];
  assign watchdog_enable_bit = control[CTL_WATCHDOG_ENABLE_BIT];
  assign watchdog_timeout_value = wd_value;
  assign master_state = ms_code;

endmodule

//--- hdl/rsu_pkg.sv
// Purpose: Shared constants and types of the upgrade status and sequencer.
// Assumes: One clock, mclk at 50 MHz, synchronous active-high reset.
// Notes: Control word and status word layouts are fixed here only.
package rsu_pkg;

  // ----------------------------------------------------------------------
  // Control and update word layout.
  // ----------------------------------------------------------------------
  localparam int CTL_W = 39;
  localparam int CTL_RSV2 = 38;
  localparam int CTL_EARLY_DONE = 37;
  localparam int CTL_OSC_INT = 36;
  localparam int CTL_WATCHDOG_ENABLE_BIT = 35;
  localparam int CTL_ADDR_HI = 33;
  localparam int CTL_ADDR_LO = 12;
  localparam int CTL_WD_HI = 11;
  localparam logic [CTL_W-1:0] CTL_RESET = 39'h00_0000_0000;

  // ----------------------------------------------------------------------
  // Status word layout.
  // ----------------------------------------------------------------------
  localparam int STAT_W = 32;
  localparam int HIST_W = 31;
  localparam int SRC_W = 5;
  localparam logic [1:0] MS_FACTORY = 2'h1;
  localparam logic [1:0] MS_APPLICATION = 2'h2;
  localparam logic [16:0] WD_LOW_BITS = 17'h00008;
  localparam logic [STAT_W-1:0] HIST_INVALID_WORD = 32'hDEAD_0BAD;

  // Source flags, one-hot, bit 4 is bit 30 of a history entry.
  localparam int SRC_EXT_RESET = 4;
  localparam int SRC_CRC = 3;
  localparam int SRC_ERR_PIN = 2;
  localparam int SRC_WATCHDOG = 1;
  localparam int SRC_FABRIC = 0;

  // Capture selections.
  localparam logic [2:0] SEL_INFO1 = 3'h0;
  localparam logic [2:0] SEL_INFO2 = 3'h1;
  localparam logic [2:0] SEL_HIST_RECENT = 3'h2;
  localparam logic [2:0] SEL_HIST_OLDER = 3'h3;
  localparam logic [2:0] SEL_CONTROL = 3'h4;

  // Least request pulse the partner must give, and its cycle count.
  localparam int REQ_MIN_NS = 250;
  localparam int CLK_PERIOD_NS = 20;
  localparam int REQ_MIN_CYC = (REQ_MIN_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RSU_ST_FACTORY = 2'b00,
    RSU_ST_APP = 2'b01,
    RSU_ST_RECORD = 2'b10,
    RSU_ST_LOAD = 2'b11
  } rsu_state_t;

endpackage

//--- hdl/rsu_shift_if.sv
// Purpose: Carries capture and update words between sequencer and shifter.
// Assumes: Both ends run on mclk.
// Notes: Update writes are allowed only while update_write_en is high.
interface rsu_shift_if;
  import rsu_pkg::*;
  logic capture_strobe;
  logic [CTL_W-1:0] capture_word;
  logic [CTL_W-1:0] update_word;
  logic update_write_en;

  modport seq (
    output capture_strobe,
    output capture_word,
    output update_write_en,
    input update_word
  );

  modport shifter (
    input capture_strobe,
    input capture_word,
    input update_write_en,
    output update_word
  );
endinterface

//--- hdl/rsu_shift_unit.sv
// Purpose: Fabric-facing shift register and update register.
// Assumes: Capture and update strobes are one-cycle pulses on mclk; shift_en shifts one bit per cycle held high.
// Notes: Data leaves and enters least significant bit first.
module rsu_shift_unit
  import rsu_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic shift_en,
  input wire logic shift_in,
  input wire logic update,
  output logic shift_out,
  rsu_shift_if.shifter sif
);

  logic [CTL_W-1:0] shreg;
  logic [CTL_W-1:0] upd;

  // --------------------------------------------------------------------
  // Shift register.
  // --------------------------------------------------------------------
  // Capture takes priority over shifting so a loaded word is not skewed.
  always_ff @(posedge mclk) begin
    if (srst) begin
      shreg <= CTL_RESET;
    end else if (sif.capture_strobe) begin
      shreg <= sif.capture_word;
    end else if (shift_en) begin
      shreg <= {shift_in, shreg[CTL_W-1:1]};
    end
  end

  // --------------------------------------------------------------------
  // Update register.
  // --------------------------------------------------------------------
  // Only a factory image may write it; otherwise the strobe is ignored.
  always_ff @(posedge mclk) begin
    if (srst) begin
      upd <= CTL_RESET;
    end else if (update && sif.update_write_en) begin
      upd <= shreg;
    end
  end

  assign shift_out = shreg[0];
  assign sif.update_word = upd;

endmodule

//--- verif/rsu_checker.sv
// Purpose: Port-level assertions for the upgrade sequencer.
// Assumes: Single mclk domain with synchronous srst.
// Notes: Attached to every sequencer through the bind at the foot.
module rsu_checker
  import rsu_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic external_config_reset,
  input wire logic config_error_pin,
  input wire logic crc_error,
  input wire logic watchdog_timeout,
  input wire logic image_loaded,
  input wire logic load_request,
  input wire logic load_application,
  input wire logic [23:0] load_address,
  input wire logic early_done_check,
  input wire logic internal_osc_select,
  input wire logic watchdog_enable_bit,
  input wire logic [28:0] watchdog_timeout_value,
  input wire logic [1:0] master_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // An error in an application records the cause, then asks for a load.
  sequence s_app_error;
    master_state == MS_APPLICATION && (crc_error || config_error_pin ||
      watchdog_timeout || external_config_reset);
  endsequence
  sequence s_record_load;
    master_state == MS_FACTORY ##1 load_request;
  endsequence
  a_error_to_load: assert property (
    s_app_error |=> s_record_load) else $error("error gave no load");
  a_error_clears_ctl: assert property (
    s_app_error |=> ##2 (load_address == 24'h0 && !load_application &&
    !(early_done_check || internal_osc_select || watchdog_enable_bit)))
    else $error("error left control bits set");

  // Fixed fields of the control word as seen at the outputs, and the boot after reset.
  a_wd_low_bits: assert property (
    watchdog_timeout_value[16:0] == WD_LOW_BITS) else $error("wd low bits");
  a_addr_word_align: assert property (
    load_address[1:0] == 2'h0) else $error("address not aligned");
  a_reset_boot_zero: assert property (
    $fell(srst) |-> load_request && load_address == 24'h0 &&
    master_state == MS_FACTORY) else $error("reset did not boot factory");

  // A load stands until the engine reports the image in place.
  a_load_holds: assert property (
    load_request && !image_loaded |=> load_request)
    else $error("load request dropped early");
  a_app_entry: assert property (
    load_request && image_loaded && load_application |=>
    master_state == MS_APPLICATION && !load_request)
    else $error("application not entered");
  a_factory_entry: assert property (
    load_request && image_loaded && !load_application |=>
    master_state == MS_FACTORY && !load_request)
    else $error("factory not entered");
endmodule

bind rsu_sequencer rsu_checker u_rsu_checker (
  .mclk(mclk),
  .srst(srst),
  .external_config_reset(external_config_reset),
  .config_error_pin(config_error_pin),
  .crc_error(crc_error),
  .watchdog_timeout(watchdog_timeout),
  .image_loaded(image_loaded),
  .load_request(load_request),
  .load_application(load_application),
  .load_address(load_address),
  .early_done_check(early_done_check),
  .internal_osc_select(internal_osc_select),
  .watchdog_enable_bit(watchdog_enable_bit),
  .watchdog_timeout_value(watchdog_timeout_value),
  .master_state(master_state)
);

//--- verif/rsu_fabric_model.sv
// Purpose: Fabric user logic driving the sequencer's shift side.
// Assumes: Strobes change just after a rising mclk edge.
// Notes: Words go in and come out least significant bit first.
module rsu_fabric_model
  import rsu_pkg::*;
(
  input wire logic mclk,
  input wire logic ru_shift_out,
  output logic ru_shift_en,
  output logic ru_shift_in,
  output logic ru_capture,
  output logic [2:0] ru_capture_sel,
  output logic ru_update,
  output logic fabric_reconfig_request
);
  timeunit 1ns;
  timeprecision 1ns;
  // All strobes start low so no stray request reaches the sequencer.
  initial begin
    {ru_shift_en, ru_shift_in, ru_capture, ru_update} = 4'h0;
    ru_capture_sel = 3'h0;
    fabric_reconfig_request = 1'b0;
  end

  // Shifts a whole word in, then copies it to the update register.
  task automatic load(input logic [CTL_W-1:0] w);
    for (int i = 0; i < CTL_W; i++) begin
      @(posedge mclk);
      ru_shift_en <= 1'b1;
      ru_shift_in <= w[i];
    end
    @(posedge mclk);
    ru_shift_en <= 1'b0;
    ru_shift_in <= ~w[CTL_W-1]; // Released line shows no stale bit.
    ru_update <= 1'b1;
    @(posedge mclk);
    ru_update <= 1'b0;
  endtask

  // Holds the request for the least time that guarantees a switch.
  task automatic pulse();
    @(posedge mclk);
    fabric_reconfig_request <= 1'b1;
    repeat (REQ_MIN_CYC) @(posedge mclk);
    fabric_reconfig_request <= 1'b0;
  endtask

  // Captures one word and reads it back a bit at each falling edge.
  task automatic read(input logic [2:0] s, output logic [CTL_W-1:0] v);
    @(posedge mclk);
    ru_capture <= 1'b1;
    ru_capture_sel <= s;
    @(posedge mclk);
    ru_capture <= 1'b0;
    ru_shift_en <= 1'b1;
    for (int i = 0; i < CTL_W; i++) begin
      @(negedge mclk);
      v[i] = ru_shift_out;
      // The last bit needs no shift after it, so the strobe drops early.
      if (i == CTL_W - 2) begin
        @(posedge mclk);
        ru_shift_en <= 1'b0;
      end
    end
  endtask
endmodule

//--- verif/rsu_sequencer_tb_top.sv
// Purpose: Self-checking bench for the upgrade status and sequencer.
// Assumes: mclk at 50 MHz, srst synchronous and active high.
// Notes: Fabric traffic comes from the fabric model instance.
module rsu_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rsu_pkg::*;
  logic mclk, ru_shift_en, ru_shift_in, ru_capture, ru_update;
  logic srst = 1'b1, image_loaded = 1'b0, external_config_reset = 1'b0;
  logic crc_error = 1'b0, config_error_pin = 1'b0, watchdog_timeout = 1'b0;
  logic fabric_reconfig_request, load_request, load_application;
  logic early_done_check, internal_osc_select, watchdog_enable_bit;
  logic ru_shift_out;
  logic [2:0] ru_capture_sel;
  logic [23:0] load_address;
  logic [28:0] watchdog_timeout_value;
  logic [1:0] master_state;
  logic [CTL_W-1:0] v, w;
  logic [31:0] prev, hexp;
  logic [27:0] c;
  int failures = 0;
  int checked = 0;
  // Cause in bits 9:5 beside the one history flag it must leave.
  logic [9:0] rows [5] = '{10'h230, 10'h188, 10'h0C4, 10'h062, 10'h021};
  wire logic [27:0] ctl_out = {early_done_check, internal_osc_select,
    watchdog_enable_bit, load_address, load_application};

  rsu_sequencer u_rsu_sequencer (
    .mclk(mclk),
    .srst(srst),
    .external_config_reset(external_config_reset),
    .config_error_pin(config_error_pin),
    .crc_error(crc_error),
    .watchdog_timeout(watchdog_timeout),
    .fabric_reconfig_request(fabric_reconfig_request),
    .image_loaded(image_loaded),
    .ru_shift_en(ru_shift_en),
    .ru_shift_in(ru_shift_in),
    .ru_capture(ru_capture),
    .ru_capture_sel(ru_capture_sel),
    .ru_update(ru_update),
    .ru_shift_out(ru_shift_out),
    .load_request(load_request),
    .load_application(load_application),
    .load_address(load_address),
    .early_done_check(early_done_check),
    .internal_osc_select(internal_osc_select),
    .watchdog_enable_bit(watchdog_enable_bit),
    .watchdog_timeout_value(watchdog_timeout_value),
    .master_state(master_state)
  );
  rsu_fabric_model u_rsu_fabric_model (
    .mclk(mclk),
    .ru_shift_out(ru_shift_out),
    .ru_shift_en(ru_shift_en),
    .ru_shift_in(ru_shift_in),
    .ru_capture(ru_capture),
    .ru_capture_sel(ru_capture_sel),
    .ru_update(ru_update),
    .fabric_reconfig_request(fabric_reconfig_request)
  );

  // Free-running clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Cuts a hang short; the tests need about 2000 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    report_and_stop();
  end

  task automatic chk(input string n, input logic [CTL_W-1:0] e,
    input logic [CTL_W-1:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Waits for a load request, then reports the image as loaded.
  task automatic boot();
    int n;
    n = 0;
    while (load_request !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    chk("load_request", 1'b1, load_request);
    @(posedge mclk) image_loaded <= 1'b1;
    @(posedge mclk) image_loaded <= 1'b0;
    @(negedge mclk);
  endtask

  // Reset, factory checks, then one application cycle per cause row.
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk("reset_ctl", '0, ctl_out);
    boot();
    chk("fact_state", MS_FACTORY, master_state);
    u_rsu_fabric_model.read(SEL_INFO1, v);
    chk("fact_word", {MS_FACTORY, 30'h0}, v[31:0]);
    u_rsu_fabric_model.read(SEL_HIST_RECENT, v);
    chk("early_hist", HIST_INVALID_WORD, v[31:0]);
    for (int i = 0; i < 5; i++) begin
      w = 39'h3B_0012_3456;
      w[17:14] = i[3:0];
      u_rsu_fabric_model.load(w);
      u_rsu_fabric_model.pulse();
      boot();
      chk("app_ctl", {w[37:35], w[33:12], 3'h1}, ctl_out);
      chk("app_state", MS_APPLICATION, master_state);
      chk("wd_value", {w[11:0], WD_LOW_BITS}, watchdog_timeout_value);
      u_rsu_fabric_model.read(SEL_INFO1, v);
      chk("info1", {MS_APPLICATION, w[35], w[11:0], WD_LOW_BITS}, v);
      u_rsu_fabric_model.read(SEL_INFO2, v);
      chk("info2", {MS_APPLICATION, 6'h0, w[33:12], 2'h0}, v[31:0]);
      u_rsu_fabric_model.load(~w);
      u_rsu_fabric_model.read(SEL_CONTROL, v);
      chk("ctl_kept", w, v);
      fork
        if (rows[i][5]) begin
          u_rsu_fabric_model.pulse();
        end
        begin
          @(posedge mclk);
          {external_config_reset, crc_error, config_error_pin,
            watchdog_timeout} <= rows[i][9:6];
          @(posedge mclk);
          {external_config_reset, crc_error, config_error_pin,
            watchdog_timeout} <= 4'h0;
        end
      join
      boot();
      c = rows[i][9:6] == 4'h0 ? {w[37:35], w[33:12], 3'h1} : 28'h0;
      chk("ctl_after", c, ctl_out);
      hexp = {1'b0, rows[i][4:0], MS_APPLICATION, w[33:12], 2'h0};
      u_rsu_fabric_model.read(SEL_HIST_RECENT, v);
      chk("hist_recent", hexp, v[31:0]);
      if (i > 0) begin
        u_rsu_fabric_model.read(SEL_HIST_OLDER, v);
        chk("hist_older", prev, v[31:0]);
      end
      prev = hexp;
    end
    // Mid-run reset, then the paths only a factory image reaches, and the unused capture select.
    @(posedge mclk) srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk("rst2_ctl", '0, ctl_out);
    boot();
    chk("rst2_state", MS_FACTORY, master_state);
    u_rsu_fabric_model.read(SEL_HIST_OLDER, v);
    chk("rst2_hist", HIST_INVALID_WORD, v[31:0]);
    u_rsu_fabric_model.load(w);
    u_rsu_fabric_model.read(SEL_CONTROL, v);
    chk("fact_update", w, v);
    u_rsu_fabric_model.read(3'h5, v);
    chk("sel_unused", '0, v);
    @(posedge mclk) crc_error <= 1'b1;
    @(posedge mclk) crc_error <= 1'b0;
    boot();
    chk("fact_err_ctl", '0, ctl_out);
    chk("fact_err_state", MS_FACTORY, master_state);
    u_rsu_fabric_model.read(SEL_HIST_RECENT, v);
    chk("fact_err_hist", HIST_INVALID_WORD, v[31:0]);
    report_and_stop();
  end
endmodule
